// ===== src/cop_pkg.sv
// Package with register map, field layout and timing constants for the object page block
// Notes on behaviour
// - Phase two length is quantum times field plus one
// - Phase one length is quantum times field plus one
// - Resync lengthens phase one or shortens phase two
// - Page bits 7-4 choose object, 0 to 14
// - Page bit 3 low enables index auto-increment
// - Control bits 7-6 encode object configuration
// - Control bit 5 flags reply ready
// - Control bit 4 selects extended identifier
// - Length code limited to 0 through 8
// - Received frame overwrites stored length code
// - Length mismatch raises status warning
// - Quantum equals clock times prescaler plus one
// - Jump width is quantum times field plus one
package cop_pkg;
    // Register addresses on the special function register port
    localparam logic [7:0] COP_ADDR_PAGE = 8'hB1;
    localparam logic [7:0] COP_ADDR_STATUS = 8'hB2;
    localparam logic [7:0] COP_ADDR_CTRL = 8'hB3;
    localparam logic [7:0] COP_ADDR_DATA = 8'hFA;
    localparam logic [7:0] COP_ADDR_TIMING = 8'hB6;
    // Reset values
    localparam logic [7:0] COP_PAGE_RST = 8'h00;
    localparam logic [7:0] COP_CTRL_RST = 8'h00;
    localparam logic [7:0] COP_TIMING_RST = 8'h00;
    // Field positions
    localparam int COP_PS2_MSB = 6;
    localparam int COP_PS2_LSB = 4;
    localparam int COP_PS1_MSB = 3;
    localparam int COP_PS1_LSB = 1;
    localparam int COP_TRIPLE_BIT = 0;
    localparam int COP_OBJ_MSB = 7;
    localparam int COP_OBJ_LSB = 4;
    localparam int COP_STEP_BIT = 3;
    localparam int COP_IDX_MSB = 2;
    localparam int COP_IDX_LSB = 0;
    localparam int COP_CFG_MSB = 7;
    localparam int COP_CFG_LSB = 6;
    localparam int COP_REPLY_BIT = 5;
    localparam int COP_EXT_BIT = 4;
    localparam int COP_DLC_MSB = 3;
    localparam int COP_DLC_LSB = 0;
    localparam int COP_WARN_BIT = 7;
    // Object count and length limits
    localparam int COP_NUM_OBJ = 15;
    localparam logic [3:0] COP_MAX_OBJ = 4'hE;
    localparam logic [3:0] COP_MAX_DLC = 4'h8;
    // Configuration codes
    localparam logic [1:0] COP_CFG_OFF = 2'h0;
    localparam logic [1:0] COP_CFG_TX = 2'h1;
    localparam logic [1:0] COP_CFG_RX = 2'h2;
    localparam logic [1:0] COP_CFG_RXBUF = 2'h3;
    // Input synchroniser depth
    localparam int COP_SYNC_STAGES = 3;
    // Bit timer states
    typedef enum logic [1:0] {COP_SYNC, COP_PROP, COP_PH1, COP_PH2} cop_seg_t;
endpackage

// ===== src/cop_bit_timer.sv
// Bit timer: quantum prescaler, segment sequencing, resync and sampling
`timescale 1ns/1ns
module cop_bit_timer (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [5:0] baud_prescaler,
    input wire logic [2:0] prop_seg,
    input wire logic [1:0] resync_jump_width,
    input wire logic [2:0] phase_seg_one,
    input wire logic [2:0] phase_seg_two,
    input wire logic triple_sample_select,
    input wire logic rx_pin,
    output logic sample_bit,
    output logic sample_strobe,
    output logic bit_start
);
    import cop_pkg::*;

    logic [2:0] rx_sync_reg; // Three-stage pin synchroniser
    logic rx_state_reg; // Debounced bus level
    logic rx_prev_reg; // Level at previous quantum
    logic [5:0] presc_reg; // Clock count within quantum
    logic tq_tick; // One-cycle quantum pulse
    cop_seg_t seg_reg; // Current segment
    logic [4:0] tq_cnt_reg; // Quanta elapsed in segment
    logic [4:0] seg_len_reg; // Length of current segment
    logic [2:0] votes_reg; // Last three quantum samples
    logic edge_seen; // Recessive-to-dominant edge
    logic [4:0] sjw_len; // Jump width in quanta

    // Majority of three samples
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    assign sjw_len = {3'h0, resync_jump_width} + 5'h01;
    assign tq_tick = (presc_reg == baud_prescaler);
    assign edge_seen = tq_tick & rx_prev_reg & ~rx_state_reg;

    // Pin synchroniser; stage one feeds only stage two
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_sync_reg <= 3'h7;
            rx_state_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
            // Accept a change once stages two and three agree
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_state_reg <= rx_sync_reg[2];
            end
        end
    end

    // Quantum prescaler, period is prescaler plus one clocks
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            presc_reg <= 6'h00;
        end else if (!enable || tq_tick) begin
            presc_reg <= 6'h00;
        end else begin
            presc_reg <= presc_reg + 6'h01;
        end
    end

    // Bus level history and vote window
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_prev_reg <= 1'b1;
            votes_reg <= 3'h7;
        end else if (tq_tick) begin
            rx_prev_reg <= rx_state_reg;
            votes_reg <= {votes_reg[1:0], rx_state_reg};
        end
    end

    // Segment sequencer with resynchronisation
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            seg_reg <= COP_SYNC;
            tq_cnt_reg <= 5'h00;
            seg_len_reg <= 5'h01;
        end else if (!enable) begin
            seg_reg <= COP_SYNC;
            tq_cnt_reg <= 5'h00;
            seg_len_reg <= 5'h01;
        end else if (tq_tick) begin
            case (seg_reg)
                COP_SYNC: begin
                    seg_reg <= COP_PROP;
                    tq_cnt_reg <= 5'h00;
                    seg_len_reg <= {2'h0, prop_seg} + 5'h01;
                end
                COP_PROP: begin
                    if (tq_cnt_reg + 5'h01 >= seg_len_reg) begin
                        seg_reg <= COP_PH1;
                        tq_cnt_reg <= 5'h00;
                        seg_len_reg <= {2'h0, phase_seg_one} + 5'h01;
                    end else begin
                        tq_cnt_reg <= tq_cnt_reg + 5'h01;
                    end
                end
                COP_PH1: begin
                    if (edge_seen) begin
                        // Late edge: lengthen phase one by the full jump width
                        seg_len_reg <= seg_len_reg + sjw_len;
                        tq_cnt_reg <= tq_cnt_reg + 5'h01;
                    end else if (tq_cnt_reg + 5'h01 >= seg_len_reg) begin
                        seg_reg <= COP_PH2;
                        tq_cnt_reg <= 5'h00;
                        seg_len_reg <= {2'h0, phase_seg_two} + 5'h01;
                    end else begin
                        tq_cnt_reg <= tq_cnt_reg + 5'h01;
                    end
                end
                default: begin
                    // Early edge: cut phase two short, restart bit
                    if (edge_seen || tq_cnt_reg + 5'h01 >= seg_len_reg) begin
                        seg_reg <= COP_SYNC;
                        tq_cnt_reg <= 5'h00;
                        seg_len_reg <= 5'h01;
                    end else begin
                        tq_cnt_reg <= tq_cnt_reg + 5'h01;
                    end
                end
            endcase
        end
    end

    // Sample point at end of phase one
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sample_bit <= 1'b1;
            sample_strobe <= 1'b0;
            bit_start <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            bit_start <= tq_tick && enable && seg_reg == COP_SYNC;
            if (enable && tq_tick && seg_reg == COP_PH1 && !edge_seen
                && tq_cnt_reg + 5'h01 >= seg_len_reg) begin
                sample_strobe <= 1'b1;
                // Majority vote only when triple sampling chosen
                sample_bit <= triple_sample_select ? maj3(votes_reg) : rx_state_reg;
            end
        end
    end
endmodule

// ===== src/cop_core.sv
// Object page select, control/length window, data window and phase timing registers
`timescale 1ns/1ns
module cop_core #(
    parameter int NUM_OBJ = 15
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic controller_active_bit,
    input wire logic [5:0] baud_prescaler,
    input wire logic [1:0] resync_jump_width,
    input wire logic [2:0] prop_seg,
    input wire logic rx_pin,
    input wire logic rx_frame_done,
    input wire logic [3:0] rx_obj,
    input wire logic [3:0] rx_length,
    output logic [NUM_OBJ-1:0] object_active_regs,
    output logic [1:0] sel_object_config,
    output logic sel_reply_ready_flag,
    output logic sel_extended_format_select,
    output logic sample_bit,
    output logic sample_strobe,
    output logic bit_start
);
    import cop_pkg::*;

    logic [7:0] page_reg; // Object select, step disable, byte pointer
    logic [7:0] timing_reg; // Phase timing register
    logic [7:0] ctrl_reg [NUM_OBJ]; // Per-object control and length
    logic [7:0] data_mem [NUM_OBJ][8]; // Per-object data bytes
    logic [NUM_OBJ-1:0] len_warn_reg; // Per-object length warning
    logic [3:0] object_select;
    logic index_step_disable;
    logic [2:0] data_byte_pointer;
    logic obj_ok; // Selected object exists
    logic data_access; // Read or write of data window
    logic [3:0] rx_len_lim; // Received length clipped to eight

    // Limit a length code to the legal range
    function automatic logic [3:0] clip_len(input logic [3:0] l);
        clip_len = (l > COP_MAX_DLC) ? COP_MAX_DLC : l;
    endfunction

    assign object_select = page_reg[COP_OBJ_MSB:COP_OBJ_LSB];
    assign index_step_disable = page_reg[COP_STEP_BIT];
    assign data_byte_pointer = page_reg[COP_IDX_MSB:COP_IDX_LSB];
    assign obj_ok = (object_select <= COP_MAX_OBJ);
    assign data_access = (sfr_wr || sfr_rd) && sfr_addr == COP_ADDR_DATA;
    assign rx_len_lim = clip_len(rx_length);

    // Page register and byte pointer stepping
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            page_reg <= COP_PAGE_RST;
        end else if (sfr_wr && sfr_addr == COP_ADDR_PAGE) begin
            page_reg <= sfr_wdata;
        end else if (data_access && !index_step_disable) begin
            // Pointer wraps seven to zero by its width
            page_reg[COP_IDX_MSB:COP_IDX_LSB] <= data_byte_pointer + 3'h1;
        end
    end

    // Phase timing register; writes ignored while controller runs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timing_reg <= COP_TIMING_RST;
        end else if (sfr_wr && sfr_addr == COP_ADDR_TIMING && !controller_active_bit) begin
            timing_reg <= {1'b0, sfr_wdata[6:0]};
        end
    end

    // Per-object control, active bits, length update and warning
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                ctrl_reg[i] <= COP_CTRL_RST;
            end
            object_active_regs <= '0;
            len_warn_reg <= '0;
        end else begin
            if (rx_frame_done && rx_obj <= COP_MAX_OBJ) begin
                // Warn when incoming length differs from expected
                if (rx_len_lim != ctrl_reg[rx_obj][COP_DLC_MSB:COP_DLC_LSB]) begin
                    len_warn_reg[rx_obj] <= 1'b1;
                end else begin
                    len_warn_reg[rx_obj] <= 1'b0;
                end
                ctrl_reg[rx_obj][COP_DLC_MSB:COP_DLC_LSB] <= rx_len_lim;
            end
            // Software write follows so frame update of other objects is kept
            if (sfr_wr && sfr_addr == COP_ADDR_CTRL && obj_ok) begin
                ctrl_reg[object_select] <= {sfr_wdata[7:4], clip_len(sfr_wdata[3:0])};
                // Active bit only follows a configuration write
                object_active_regs[object_select] <=
                    (sfr_wdata[COP_CFG_MSB:COP_CFG_LSB] != COP_CFG_OFF);
            end
        end
    end

    // Data window storage, no reset needed for payload
    always_ff @(posedge ref_clk) begin
        if (sfr_wr && sfr_addr == COP_ADDR_DATA && obj_ok) begin
            data_mem[object_select][data_byte_pointer] <= sfr_wdata;
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_addr == COP_ADDR_PAGE) begin
            sfr_rdata = page_reg;
        end else if (sfr_addr == COP_ADDR_CTRL && obj_ok) begin
            sfr_rdata = ctrl_reg[object_select];
        end else if (sfr_addr == COP_ADDR_STATUS && obj_ok) begin
            sfr_rdata[COP_WARN_BIT] = len_warn_reg[object_select];
        end else if (sfr_addr == COP_ADDR_DATA && obj_ok) begin
            sfr_rdata = data_mem[object_select][data_byte_pointer];
        end else if (sfr_addr == COP_ADDR_TIMING) begin
            sfr_rdata = timing_reg;
        end
    end

    // Selected object's decoded control fields
    always_comb begin
        sel_object_config = COP_CFG_OFF;
        sel_reply_ready_flag = 1'b0;
        sel_extended_format_select = 1'b0;
        if (obj_ok) begin
            sel_object_config = ctrl_reg[object_select][COP_CFG_MSB:COP_CFG_LSB];
            sel_reply_ready_flag = ctrl_reg[object_select][COP_REPLY_BIT];
            sel_extended_format_select = ctrl_reg[object_select][COP_EXT_BIT];
        end
    end

    // Bit timer driven from the phase timing fields
    cop_bit_timer u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .enable(controller_active_bit),
        .baud_prescaler(baud_prescaler),
        .prop_seg(prop_seg),
        .resync_jump_width(resync_jump_width),
        .phase_seg_one(timing_reg[COP_PS1_MSB:COP_PS1_LSB]),
        .phase_seg_two(timing_reg[COP_PS2_MSB:COP_PS2_LSB]),
        .triple_sample_select(timing_reg[COP_TRIPLE_BIT]),
        .rx_pin(rx_pin),
        .sample_bit(sample_bit),
        .sample_strobe(sample_strobe),
        .bit_start(bit_start)
    );
endmodule

// ===== verif/cop_core_props.sv
// Checker for page, control, timing and receive behaviour of the core
`timescale 1ns/1ns
module cop_core_props
import cop_pkg::*;
#(parameter int NUM_OBJ = 15) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic controller_active_bit,
    input wire logic [5:0] baud_prescaler,
    input wire logic rx_frame_done,
    input wire logic [3:0] rx_obj,
    input wire logic [3:0] rx_length,
    input wire logic [NUM_OBJ-1:0] object_active_regs,
    input wire logic sample_strobe,
    input wire logic bit_start
);
    logic [3:0] obj_reg; // Object chosen by the last page write
    logic [2:0] ph2_reg; // Phase two field of the last accepted timing write
    logic [11:0] gap_reg; // Cycles since the sample point, FFF when unknown
    // Shadow of the fields the assertions need
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            obj_reg <= 4'h0;
            ph2_reg <= 3'h0;
        end else if (sfr_wr && sfr_addr == COP_ADDR_PAGE) begin
            obj_reg <= sfr_wdata[7:4];
        end else if (sfr_wr && sfr_addr == COP_ADDR_TIMING && !controller_active_bit) begin
            ph2_reg <= sfr_wdata[6:4];
        end
    end
    // Gap counter; invalid while off so the first bit after enable is not judged
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= 12'hFFF;
        end else if (!controller_active_bit) begin
            gap_reg <= 12'hFFF;
        end else if (sample_strobe) begin
            gap_reg <= 12'h000;
        end else if (gap_reg != 12'hFFF) begin
            gap_reg <= gap_reg + 12'h001;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_page_rw: assert property (
        sfr_wr && sfr_addr == COP_ADDR_PAGE ##1 sfr_addr == COP_ADDR_PAGE
        |-> sfr_rdata == $past(sfr_wdata)) else $error("page readback wrong");
    a_timing_write: assert property (
        sfr_wr && sfr_addr == COP_ADDR_TIMING && !controller_active_bit ##1
        sfr_addr == COP_ADDR_TIMING |-> sfr_rdata == {1'b0, $past(sfr_wdata[6:0])})
        else $error("timing readback wrong");
    a_timing_locked: assert property (
        sfr_wr && sfr_addr == COP_ADDR_TIMING && controller_active_bit ##1
        sfr_addr == COP_ADDR_TIMING |-> $stable(sfr_rdata)) else $error("timing changed while on");
    a_index_step: assert property (
        sfr_addr == COP_ADDR_PAGE && !sfr_wr && sfr_rdata[7:3] != 5'h1E && !sfr_rdata[3]
        ##1 sfr_addr == COP_ADDR_DATA && (sfr_wr || sfr_rd) ##1 sfr_addr == COP_ADDR_PAGE
        |-> sfr_rdata[2:0] == $past(sfr_rdata[2:0], 2) + 3'h1) else $error("index not stepped");
    a_index_hold: assert property (
        sfr_addr == COP_ADDR_PAGE && !sfr_wr && sfr_rdata[3] ##1 sfr_addr == COP_ADDR_DATA
        ##1 sfr_addr == COP_ADDR_PAGE |-> sfr_rdata == $past(sfr_rdata, 2))
        else $error("index moved while held");
    a_active_set: assert property (
        sfr_wr && sfr_addr == COP_ADDR_CTRL && sfr_wdata[7:6] != COP_CFG_OFF && obj_reg != 4'hF
        |=> object_active_regs[$past(obj_reg)]) else $error("active bit not set");
    a_rx_length: assert property (
        rx_frame_done && rx_obj == obj_reg && rx_obj != 4'hF && !sfr_wr ##1
        sfr_addr == COP_ADDR_CTRL
        |-> sfr_rdata[3:0] == $past(rx_length > COP_MAX_DLC ? COP_MAX_DLC : rx_length))
        else $error("received length not stored");
    a_phase_two: assert property (
        // Phase two plus the sync quantum lie between sample point and bit start
        bit_start && gap_reg != 12'hFFF |-> gap_reg <= (ph2_reg + 2) * (baud_prescaler + 1) - 1)
        else $error("phase two too long");
    c_frame: cover property (rx_frame_done && rx_obj == obj_reg);
    c_locked: cover property (sfr_wr && sfr_addr == COP_ADDR_TIMING && controller_active_bit);
    c_bit: cover property (bit_start && gap_reg != 12'hFFF);
endmodule

// ===== verif/cop_can_node.sv
// Behavioural far-side node: drives bus bits and reports finished frames
`timescale 1ns/1ns
module cop_can_node #(parameter int BIT_CLKS = 13) (
    input wire logic ref_clk,
    output logic rx_pin,
    output logic rx_frame_done,
    output logic [3:0] rx_obj,
    output logic [3:0] rx_length
);
    // Bus idles recessive between frames
    initial begin
        rx_pin = 1'b1;
        rx_frame_done = 1'b0;
        {rx_obj, rx_length} = 8'h00;
    end
    // Random bits at a rate unrelated to the core's, then the frame report
    task automatic send(input logic [3:0] obj, input logic [3:0] len, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            @(posedge ref_clk);
            rx_pin <= 1'($urandom);
            repeat (BIT_CLKS - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rx_pin <= 1'b1;
        rx_frame_done <= 1'b1;
        rx_obj <= obj;
        rx_length <= len;
        @(posedge ref_clk);
        rx_frame_done <= 1'b0;
        rx_length <= ~len; // Stale after the report, never trusted
    endtask
    // Hold the bus at one level for a number of clocks
    task automatic hold(input logic lvl, input int n);
        @(posedge ref_clk);
        rx_pin <= lvl;
        repeat (n) @(posedge ref_clk);
    endtask
endmodule

// ===== verif/can_object_page_and_phase_timing_test.sv
// Self-checking bench for the object page, control and phase timing core
`timescale 1ns/1ns
module can_object_page_and_phase_timing_test;
    import cop_pkg::*;
    logic ref_clk, resetn, sfr_wr, sfr_rd, controller_active_bit;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [5:0] baud_prescaler;
    logic [2:0] prop_seg;
    logic [1:0] resync_jump_width, sel_object_config;
    logic rx_pin, rx_frame_done, sample_bit, sample_strobe, bit_start;
    logic sel_reply_ready_flag, sel_extended_format_select;
    logic [3:0] rx_obj, rx_length;
    logic [14:0] object_active_regs, act_mask;
    logic [7:0] mem [15][8];
    logic [7:0] ctl [15];
    int miscompares, n_checks, strobes;
    cop_core #(.NUM_OBJ(15)) dut (.ref_clk, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
        .sfr_rdata, .controller_active_bit, .baud_prescaler, .resync_jump_width, .prop_seg,
        .rx_pin, .rx_frame_done, .rx_obj, .rx_length, .object_active_regs, .sel_object_config,
        .sel_reply_ready_flag, .sel_extended_format_select, .sample_bit, .sample_strobe,
        .bit_start);
    cop_can_node #(.BIT_CLKS(13)) node (.ref_clk, .rx_pin, .rx_frame_done, .rx_obj, .rx_length);
    // One register cycle: levels set at the edge, strobes last one cycle
    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= w;
        sfr_rd <= r;
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Stored length after a frame: oversize codes saturate
    function automatic logic [3:0] clip(input logic [3:0] l);
        return (l > 4'h8) ? 4'h8 : l;
    endfunction
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (sample_strobe === 1'b1) strobes++;
    // Whole run is under two thousand cycles; the 50000-cycle limit allows over twenty times that
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    initial begin
        logic [7:0] t;
        logic [3:0] o, l;
        logic [2:0] ix;
        void'($urandom(29));
        {resetn, sfr_wr, sfr_rd, controller_active_bit} = 4'h0;
        {sfr_addr, sfr_wdata} = 16'h0000;
        baud_prescaler = 6'($urandom_range(2));
        prop_seg = 3'($urandom_range(3));
        resync_jump_width = 2'($urandom);
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(COP_ADDR_PAGE, 8'h00, 0, 0);
        chk("page reset", 8'h00, sfr_rdata);
        bus(8'h00, 8'h00, 0, 0);
        chk("unmapped", 8'h00, sfr_rdata);
        // Both sampling modes, each with a dominant and a recessive stretch
        for (int pass = 0; pass < 2; pass++) begin
            t = {1'b0, 6'($urandom), 1'(pass)}; // Top bit kept clear
            bus(COP_ADDR_TIMING, t, 1, 0);
            bus(COP_ADDR_TIMING, 8'h00, 0, 0);
            chk("timing", t, sfr_rdata);
            @(posedge ref_clk);
            controller_active_bit <= 1'b1;
            bus(COP_ADDR_TIMING, ~t & 8'h7F, 1, 0);
            bus(COP_ADDR_TIMING, 8'h00, 0, 0);
            chk("timing locked", t, sfr_rdata);
            node.send(4'hF, 4'h3, 30);
            node.hold(1'b0, 100);
            chk("dominant sample", 0, sample_bit);
            node.hold(1'b1, 100);
            chk("recessive sample", 1, sample_bit);
            controller_active_bit <= 1'b0;
        end
        chk("sample points", 1, strobes > 0);
        $display("test timing done");
        for (int ob = 0; ob < 15; ob++) begin
            o = 4'(ob);
            ctl[ob] = {2'(ob), 2'($urandom), 4'($urandom_range(8))};
            act_mask[ob] = (ob % 4) != 0;
            bus(COP_ADDR_PAGE, {o, 4'h0}, 1, 0);
            bus(COP_ADDR_CTRL, ctl[ob], 1, 0);
            bus(COP_ADDR_CTRL, 8'h00, 0, 0);
            chk("control", ctl[ob], sfr_rdata);
            chk("fields", ctl[ob][7:4], {sel_object_config, sel_reply_ready_flag,
                sel_extended_format_select});
            for (int i = 0; i < 8; i++) begin
                mem[ob][i] = 8'($urandom);
                bus(COP_ADDR_DATA, mem[ob][i], 1, 0);
                bus(COP_ADDR_PAGE, 8'h00, 0, 0);
                chk("pointer", {o, 1'b0, 3'(i + 1)}, sfr_rdata);
            end
        end
        chk("active", act_mask, object_active_regs);
        $display("test objects done");
        for (int ob = 0; ob < 15; ob += 7) begin
            o = 4'(ob);
            ix = 3'($urandom);
            bus(COP_ADDR_PAGE, {o, 4'h0}, 1, 0);
            for (int i = 0; i < 8; i++) begin
                bus(COP_ADDR_DATA, 8'h00, 0, 1);
                chk("data", mem[ob][i], sfr_rdata);
            end
            bus(COP_ADDR_PAGE, {o, 1'b1, ix}, 1, 0);
            bus(COP_ADDR_PAGE, 8'h00, 0, 0);
            bus(COP_ADDR_DATA, 8'h00, 0, 1);
            chk("held data", mem[ob][ix], sfr_rdata);
            bus(COP_ADDR_PAGE, 8'h00, 0, 0);
            chk("held pointer", {o, 1'b1, ix}, sfr_rdata);
        end
        bus(COP_ADDR_PAGE, 8'hF0, 1, 0);
        bus(COP_ADDR_CTRL, 8'h55, 1, 0);
        bus(COP_ADDR_CTRL, 8'h00, 0, 0);
        chk("object 15", 8'h00, sfr_rdata);
        $display("test readback done");
        for (int k = 0; k < 8; k++) begin
            o = 4'($urandom_range(14));
            l = (k == 7) ? 4'hB : 4'($urandom_range(8)); // Last one oversize
            bus(COP_ADDR_PAGE, {o, 4'h0}, 1, 0);
            bus(COP_ADDR_CTRL, 8'h00, 0, 0);
            node.send(o, l, 3);
            bus(COP_ADDR_CTRL, 8'h00, 0, 0);
            chk("rx length", clip(l), sfr_rdata[3:0]);
            bus(COP_ADDR_STATUS, 8'h00, 0, 0);
            chk("length warn", clip(l) != ctl[o][3:0], sfr_rdata[7]);
            ctl[o][3:0] = clip(l);
        end
        bus(COP_ADDR_PAGE, 8'h10, 1, 0);
        bus(COP_ADDR_CTRL, 8'h00, 1, 0);
        bus(COP_ADDR_CTRL, 8'h00, 0, 0);
        act_mask[1] = 1'b0;
        chk("active cleared", act_mask, object_active_regs);
        $display("test receive done");
        print_verdict();
    end
endmodule
bind cop_core cop_core_props #(.NUM_OBJ(NUM_OBJ)) props (.ref_clk, .resetn, .sfr_addr,
    .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .controller_active_bit, .baud_prescaler,
    .rx_frame_done, .rx_obj, .rx_length, .object_active_regs, .sample_strobe, .bit_start);
